//--- verilog/otc_term_ctrl.sv
// On-die termination selection and timing with an APB register file
`timescale 1ns/1ps
// Summary of operation
// - Synchronous termination timing while DLL locked
// - Nominal follows sampled pin after latency
// - One-cycle preamble pin latency is WL-2
// - Two-cycle preamble pin latency is WL-3
// - Read turns termination off after latency
// - Park returns after read window closes
// - No termination while driving read data
// - Dynamic write termination when write value nonzero
// - Values from mode register fields
// - Idle: nominal by pin, park when low
// - Write selects write termination after latency
// - Write termination drops after burst window
// - Write release adjusted by CRC, preamble
// - Read beats write beats nominal beats park
// - Pin ignored when nominal zero or self-refresh
// - Self-refresh forces all termination off
module otc_term_ctrl
  import otc_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Command decode and device state
  input  wire logic        cmd_read,
  input  wire logic        cmd_write,
  input  wire logic        cmd_chop4,
  input  wire logic        dll_locked,
  input  wire logic        self_refresh,
  // Termination pin from the controller
  input  wire logic        termination_control_pin,
  // Termination to the pad
  output otc_term_type     term_sel,
  output logic      [2:0]  term_value,
  output logic             term_enable
);
  // Registers and their next values
  logic [31:0]   timing_r;
  logic [31:0]   timing_nxt;
  logic [31:0]   mode_r;
  logic [31:0]   mode_nxt;
  logic [31:0]   prdata_r;
  logic [31:0]   prdata_nxt;
  logic          pin_s1_r;
  logic          pin_s2_r;
  otc_term_type  term_sel_r;
  otc_term_type  term_sel_nxt;
  logic [2:0]    term_val_r;
  logic [2:0]    term_val_nxt;
  logic          term_en_r;
  logic          term_en_nxt;

  // Decoded fields
  logic [4:0]       cwl;
  logic [4:0]       add_lat;
  logic [2:0]       par_lat;
  logic             pre2;
  logic             crc_en;
  otc_burst_type    burst;
  logic [2:0]       nom_val;
  logic [1:0]       wr_val;
  logic [2:0]       park_val;
  logic             dyn_en;
  logic             nom_ok;

  // Latencies and windows
  logic [LAT_W-1:0] wl_lat;
  logic [LAT_W-1:0] base_lat;
  logic [LAT_W-1:0] pin_dly;
  logic [LAT_W-1:0] cmd_dly;
  logic             rd_chop;
  logic             wr_chop;
  logic [DLY_W-1:0] pin_q;
  logic [DLY_W-1:0] rd_q;
  logic [DLY_W-1:0] wr_q;
  logic [WIN_W-1:0] rd_len;
  logic [WIN_W-1:0] wr_len;
  logic             rd_act;
  logic             wr_act;
  logic             wr_start;

  // APB decode
  logic             acc;
  logic             hit;

  // Chooses the window length for chop or full burst
  function automatic logic [WIN_W-1:0] win_len(
    input logic             chop,
    input logic [WIN_W-1:0] l4,
    input logic [WIN_W-1:0] l8
  );
    win_len = chop ? l4 : l8;
  endfunction

  // Per-command chop decision; fixed modes override the command bit
  function automatic logic is_chop(
    input otc_burst_type b,
    input logic          otf_chop
  );
    is_chop = (b == BURST_FIXED4) || ((b == BURST_OTF) && otf_chop);
  endfunction

  // Field extraction
  assign cwl      = timing_r[TIM_CWL_LSB +: 5];
  assign add_lat  = timing_r[TIM_AL_LSB +: 5];
  assign par_lat  = timing_r[TIM_PL_LSB +: 3];
  assign pre2     = timing_r[TIM_PRE2_BIT];
  assign crc_en   = timing_r[TIM_CRC_BIT];
  assign burst    = otc_burst_type'(timing_r[TIM_BURST_LSB +: 2]);
  assign nom_val  = mode_r[MODE_NOM_LSB +: 3];
  assign wr_val   = mode_r[MODE_WR_LSB +: 2];
  assign park_val = mode_r[MODE_PARK_LSB +: 3];
  assign dyn_en   = wr_val[0] | wr_val[1];

  // Pin counts only with a locked DLL, nominal set, no self-refresh
  assign nom_ok = dll_locked && !self_refresh && (nom_val != '0);

  // Write latency and the shared turn-on base
  assign wl_lat   = LAT_W'(cwl) + LAT_W'(add_lat) + LAT_W'(par_lat);
  assign base_lat = wl_lat - (pre2 ? PRE2_SUB : PRE1_SUB);
  // Synchroniser stages and output register eat part of the latency
  assign pin_dly  = base_lat - PIN_PATH;
  assign cmd_dly  = base_lat - CMD_PATH;

  // Two-flop synchroniser; stage one feeds only stage two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
    end else begin
      pin_s1_r <= termination_control_pin;
      pin_s2_r <= pin_s1_r;
    end
  end

  // Same delay for on and off, so the pin level itself is delayed
  otc_delay_line u_pin_dly (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({1'b0, pin_s2_r}),
    .dly     (pin_dly),
    .q       (pin_q)
  );

  assign rd_chop = is_chop(burst, cmd_chop4);
  assign wr_chop = is_chop(burst, cmd_chop4);

  // Read and write pulses carry their chop flag down the line
  otc_delay_line u_rd_dly (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({rd_chop, cmd_read}),
    .dly     (cmd_dly),
    .q       (rd_q)
  );

  otc_delay_line u_wr_dly (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({wr_chop, cmd_write}),
    .dly     (cmd_dly),
    .q       (wr_q)
  );

  // Read disable window, widened by preamble and CRC
  assign rd_len = win_len(rd_q[1], LEN_CHOP4, LEN_BURST8)
                + (pre2 ? PRE2_ADD : 4'h0)
                + (crc_en ? RD_CRC_ADD : 4'h0);

  // Write window from the dynamic latency table
  assign wr_len = win_len(wr_q[1],
                          LEN_CHOP4 + (crc_en ? WR4_CRC_ADD : 4'h0),
                          LEN_BURST8 + (crc_en ? WR8_CRC_ADD : 4'h0))
                + (pre2 ? PRE2_ADD : 4'h0);

  // Dynamic mode gates writes at the switch point
  assign wr_start = wr_q[0] && dyn_en;

  otc_window u_rd_win (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (rd_q[0]),
    .len     (rd_len),
    .active  (rd_act)
  );

  otc_window u_wr_win (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (wr_start),
    .len     (wr_len),
    .active  (wr_act)
  );

  // Termination priority; read window covers postamble before restore
  always_comb begin
    term_sel_nxt = TERM_OFF;
    term_val_nxt = 3'h0;
    if (self_refresh) begin
      term_sel_nxt = TERM_OFF;
    end else if (rd_act) begin
      term_sel_nxt = TERM_OFF;
    end else if (wr_act) begin
      term_sel_nxt = TERM_WR;
      term_val_nxt = {1'b0, wr_val};
    end else if (pin_q[0] && nom_ok) begin
      term_sel_nxt = TERM_NOM;
      term_val_nxt = nom_val;
    end else if (park_val != '0) begin
      term_sel_nxt = TERM_PARK;
      term_val_nxt = park_val;
    end
    term_en_nxt = (term_sel_nxt != TERM_OFF);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_sel_r <= TERM_OFF;
      term_val_r <= 3'h0;
      term_en_r  <= 1'b0;
    end else begin
      term_sel_r <= term_sel_nxt;
      term_val_r <= term_val_nxt;
      term_en_r  <= term_en_nxt;
    end
  end

  assign term_sel    = term_sel_r;
  assign term_value  = term_val_r;
  assign term_enable = term_en_r;

  // APB: zero wait states, read data staged in the setup cycle
  assign acc = psel && penable;
  assign hit = (paddr == OFS_TIMING) || (paddr == OFS_MODE) ||
               (paddr == OFS_STATUS);

  always_comb begin
    timing_nxt = timing_r;
    mode_nxt   = mode_r;
    prdata_nxt = prdata_r;
    if (acc && pwrite && (paddr == OFS_TIMING)) begin
      timing_nxt = pwdata & TIM_MASK;
    end
    if (acc && pwrite && (paddr == OFS_MODE)) begin
      mode_nxt = pwdata & MODE_MASK;
    end
    if (psel && !penable && !pwrite) begin
      prdata_nxt = 32'h0000_0000;
      case (paddr)
        OFS_TIMING: prdata_nxt = timing_r;
        OFS_MODE:   prdata_nxt = mode_r;
        OFS_STATUS: begin
          prdata_nxt[ST_SEL_LSB +: 2]  = term_sel_r;
          prdata_nxt[ST_EN_BIT]        = term_en_r;
          prdata_nxt[ST_PIN_BIT]       = pin_s2_r;
          prdata_nxt[ST_RD_BIT]        = rd_act;
          prdata_nxt[ST_WR_BIT]        = wr_act;
          prdata_nxt[ST_WL_LSB +: LAT_W] = wl_lat;
        end
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timing_r <= TIM_RST;
      mode_r   <= MODE_RST;
      prdata_r <= 32'h0000_0000;
    end else begin
      timing_r <= timing_nxt;
      mode_r   <= mode_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  // Unmapped addresses answer with an error, writes there are dropped
  assign pslverr = acc && !hit;

  // Checks on the termination decisions and unmapped APB writes
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_read_open;
    !rd_act ##1 rd_act;
  endsequence

  sequence s_write_open;
    !wr_act ##1 wr_act;
  endsequence

  a_selfref_all_off: assert property (
    self_refresh |=> (term_sel_r == TERM_OFF) && !term_en_r)
    else $error("termination on during self-refresh");

  a_read_drives_off: assert property (
    rd_act |=> term_sel_r == TERM_OFF)
    else $error("termination on while read data driven");

  a_write_beats_nom: assert property (
    (wr_act && !rd_act && !self_refresh) |=> term_sel_r == TERM_WR)
    else $error("write termination not chosen");

  a_no_dyn_write: assert property (
    (!dyn_en && !wr_act) |=> term_sel_r != TERM_WR)
    else $error("write termination without dynamic mode");

  a_nom_ignored: assert property (
    (nom_val == 3'h0 || self_refresh || !dll_locked)
    |=> term_sel_r != TERM_NOM)
    else $error("pin honoured while nominal disabled");

  a_park_idle: assert property (
    (!rd_act && !wr_act && !self_refresh && !pin_q[0] &&
     park_val != 3'h0) |=> term_sel_r == TERM_PARK)
    else $error("park not applied with pin low");

  a_pin_nominal: assert property (
    (pin_q[0] && nom_ok && !rd_act && !wr_act)
    |=> (term_sel_r == TERM_NOM) && (term_val_r == $past(nom_val)))
    else $error("nominal termination not applied");

  a_read_window: assert property (
    s_read_open |-> rd_act[*4])
    else $error("read disable window shorter than four");

  a_write_window: assert property (
    s_write_open |-> wr_act[*4] ##[0:5] !wr_act)
    else $error("write window length out of range");

  a_apb_unmapped: assert property (
    (acc && !hit && pwrite) |=> $stable(timing_r) && $stable(mode_r))
    else $error("unmapped write changed a register");
endmodule

//--- common/otc_pkg.sv
// Constants, field layout and types for the termination controller
package otc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_TIMING = 8'h00;
  localparam logic [7:0] OFS_MODE   = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  // Timing register fields
  localparam int unsigned TIM_CWL_LSB   = 0;
  localparam int unsigned TIM_AL_LSB    = 5;
  localparam int unsigned TIM_PL_LSB    = 10;
  localparam int unsigned TIM_PRE2_BIT  = 13;
  localparam int unsigned TIM_CRC_BIT   = 14;
  localparam int unsigned TIM_BURST_LSB = 15;
  localparam logic [31:0] TIM_MASK      = 32'h0001_ffff;
  localparam logic [31:0] TIM_RST       = 32'h0000_0009;

  // Mode register copy fields
  localparam int unsigned MODE_NOM_LSB  = 0;
  localparam int unsigned MODE_WR_LSB   = 3;
  localparam int unsigned MODE_PARK_LSB = 5;
  localparam logic [31:0] MODE_MASK     = 32'h0000_00ff;
  localparam logic [31:0] MODE_RST      = 32'h0000_0000;

  // Status register fields
  localparam int unsigned ST_SEL_LSB = 0;
  localparam int unsigned ST_EN_BIT  = 2;
  localparam int unsigned ST_PIN_BIT = 3;
  localparam int unsigned ST_RD_BIT  = 4;
  localparam int unsigned ST_WR_BIT  = 5;
  localparam int unsigned ST_WL_LSB  = 8;

  // Latency arithmetic
  localparam int unsigned LAT_W     = 7;
  localparam int unsigned WIN_W     = 4;
  localparam int unsigned DLY_W     = 2;
  localparam int unsigned DLY_DEPTH = 127;
  localparam logic [LAT_W-1:0] PRE1_SUB = 7'h02;
  localparam logic [LAT_W-1:0] PRE2_SUB = 7'h03;
  localparam logic [LAT_W-1:0] PIN_PATH = 7'h02;
  localparam logic [LAT_W-1:0] CMD_PATH = 7'h00;

  // Window lengths in cycles
  localparam logic [WIN_W-1:0] LEN_CHOP4    = 4'h4;
  localparam logic [WIN_W-1:0] LEN_BURST8   = 4'h6;
  localparam logic [WIN_W-1:0] WR4_CRC_ADD  = 4'h3;
  localparam logic [WIN_W-1:0] WR8_CRC_ADD  = 4'h1;
  localparam logic [WIN_W-1:0] RD_CRC_ADD   = 4'h1;
  localparam logic [WIN_W-1:0] PRE2_ADD     = 4'h1;

  typedef enum logic [1:0] {
    BURST_FIXED8,
    BURST_FIXED4,
    BURST_OTF,
    BURST_RSVD
  } otc_burst_type;

  typedef enum logic [1:0] {
    TERM_OFF,
    TERM_PARK,
    TERM_NOM,
    TERM_WR
  } otc_term_type;
endpackage

//--- verilog/otc_delay_line.sv
// Tapped shift line delaying a small word by a programmable count
`timescale 1ns/1ps
module otc_delay_line
  import otc_pkg::*;
(
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Data in and tap select
  input  wire logic [DLY_W-1:0] din,
  input  wire logic [LAT_W-1:0] dly,
  // Delayed data
  output logic      [DLY_W-1:0] q
);
  logic [DLY_W-1:0] line_r [DLY_DEPTH];
  logic [DLY_W-1:0] line_nxt [DLY_DEPTH];
  logic [DLY_W-1:0] q_r;
  logic [DLY_W-1:0] q_nxt;

  // Shift by one each cycle; tap 0 is the live input
  always_comb begin
    line_nxt[0] = din;
    for (int i = 1; i < DLY_DEPTH; i++) begin
      line_nxt[i] = line_r[i-1];
    end
    // Count of 1 taps the input, so total delay equals dly
    if (dly == '0) begin
      q_nxt = din;
    end else if (dly == 7'h01) begin
      q_nxt = din;
    end else begin
      q_nxt = line_r[dly - 7'h02];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DLY_DEPTH; i++) begin
        line_r[i] <= '0;
      end
      q_r <= '0;
    end else begin
      line_r <= line_nxt;
      q_r    <= q_nxt;
    end
  end

  assign q = q_r;
endmodule

//--- verilog/otc_window.sv
// Retriggerable window timer, active from the start pulse for len cycles
`timescale 1ns/1ps
module otc_window
  import otc_pkg::*;
(
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Start and length
  input  wire logic             start,
  input  wire logic [WIN_W-1:0] len,
  // Window state
  output logic                  active
);
  logic [WIN_W-1:0] cnt_r;
  logic [WIN_W-1:0] cnt_nxt;

  // Restart on every start so back to back bursts merge
  always_comb begin
    cnt_nxt = cnt_r;
    if (start) begin
      cnt_nxt = len - 4'h1;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Start counts as the first cycle to save a register stage
  assign active = start | (cnt_r != '0);
endmodule

//--- sim/otc_ctrl_model.sv
// Behavioural memory controller driving commands and the termination pin
`timescale 1ns/1ps
module otc_ctrl_model (
  // Clock
  input  wire logic pclk,
  // Mode settings that set the pin hold
  input  wire logic pre2,
  input  wire logic crc,
  input  wire logic bl4,
  // Commands and pin toward the device
  output logic      cmd_read,
  output logic      cmd_write,
  output logic      cmd_chop4,
  output logic      termination_control_pin
);
  // Quiet lines at time zero
  initial begin
    cmd_read = 1'b0;
    cmd_write = 1'b0;
    cmd_chop4 = 1'b0;
    termination_control_pin = 1'b0;
  end

  // One command cycle; chop flips when idle so no stale level looks valid
  task automatic cmd(input logic rd, input logic wr, input logic ch);
    cmd_read <= rd;
    cmd_write <= wr;
    cmd_chop4 <= ch;
    @(posedge pclk);
    cmd_read <= 1'b0;
    cmd_write <= 1'b0;
    cmd_chop4 <= ~ch;
  endtask

  // Pin high for the minimum hold plus some slack
  task automatic pin_pulse(input int extra);
    int hold;
    hold = (bl4 ? 4 : 8) + ((crc | pre2) ? 2 : 0);
    termination_control_pin <= 1'b1;
    repeat (hold + extra) @(posedge pclk);
    termination_control_pin <= 1'b0;
  endtask
endmodule

//--- sim/otc_term_ctrl_tb.sv
// Self-checking bench for the termination controller
`timescale 1ns/1ps
module otc_term_ctrl_tb;
  import otc_pkg::*;
  logic         pclk, presetn, psel, penable, pwrite;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata;
  logic         pready, pslverr, cmd_read, cmd_write, cmd_chop4;
  logic         dll_locked, self_refresh, termination_control_pin;
  otc_term_type term_sel;
  logic [2:0]   term_value, nom, park;
  logic         term_enable;
  logic [1:0]   burst, wrf;
  bit           pre2, crc, chk_on;
  bit           rd_act [0:8191];
  bit           wr_act [0:8191];
  bit           pin_h  [0:8191];
  bit           sr_h   [0:8191];
  bit           dl_h   [0:8191];
  int           cyc, wl, bb, seed, n_fail, compares;
  logic [31:0]  rv;
  logic         ev;
  logic [31:0]  tws [0:5] = '{32'h9, 32'h2009, 32'hc04b, 32'h17069,
                             32'h1000a, 32'h1c009};

  otc_term_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_read(cmd_read), .cmd_write(cmd_write), .cmd_chop4(cmd_chop4),
    .dll_locked(dll_locked), .self_refresh(self_refresh),
    .termination_control_pin(termination_control_pin),
    .term_sel(term_sel), .term_value(term_value),
    .term_enable(term_enable));

  otc_ctrl_model ctl (.pclk(pclk), .pre2(pre2), .crc(crc),
    .bl4(burst == 2'd1), .cmd_read(cmd_read), .cmd_write(cmd_write),
    .cmd_chop4(cmd_chop4),
    .termination_control_pin(termination_control_pin));

  // Clock
  always #5 pclk = ~pclk;

  task automatic end_sim();
    if (n_fail == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_fail++;
      end_sim();
    end
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Mark the cycles a read or write window covers
  function automatic void mark(bit rd, int c, logic ch);
    int l;
    bit c4;
    c4 = (burst == 2'd1) || (burst == 2'd2 && ch === 1'b1);
    if (rd)
      l = (c4 ? 4 : 6) + pre2 + crc;
    else
      l = c4 ? 4 + 3 * crc + pre2 : 6 + (crc | pre2) + (crc & pre2);
    for (int k = bb; k < bb + l; k++)
      if (rd) rd_act[c + k] = 1'b1;
      else wr_act[c + k] = 1'b1;
  endfunction

  // Expected pad state after edge t
  function automatic logic [31:0] expv(int t);
    otc_term_type s;
    logic [2:0]   v;
    s = TERM_OFF;
    v = 3'h0;
    if (sr_h[t] || rd_act[t])
      s = TERM_OFF;
    else if (wr_act[t] && wrf != 2'h0) begin
      s = TERM_WR;
      v = {1'b0, wrf};
    end else if (pin_h[t - bb] && nom != 3'h0 && dl_h[t]) begin
      s = TERM_NOM;
      v = nom;
    end else if (park != 3'h0) begin
      s = TERM_PARK;
      v = park;
    end
    return {26'h0, s, v, s != TERM_OFF};
  endfunction

  // Record what the device sampled at each edge
  always @(posedge pclk) begin
    if (presetn) begin
      cyc = cyc + 1;
      pin_h[cyc] = termination_control_pin;
      sr_h[cyc] = self_refresh;
      dl_h[cyc] = dll_locked;
      if (cmd_read === 1'b1) mark(1'b1, cyc, cmd_chop4);
      if (cmd_write === 1'b1) mark(1'b0, cyc, cmd_chop4);
    end
  end

  // Compare the pad state once it has settled
  always @(negedge pclk) begin
    if (chk_on)
      check({26'h0, term_sel, term_value, term_enable}, expv(cyc));
  end

  // New timing and mode; long idle so no window spans the change
  task automatic cfg(input logic [31:0] tw, input logic [31:0] mw);
    chk_on = 1'b0;
    apb(1'b1, OFS_TIMING, tw);
    apb(1'b1, OFS_MODE, mw);
    {burst, crc, pre2} = tw[16:13];
    {park, wrf, nom} = mw[7:0];
    wl = int'(tw[4:0]) + int'(tw[9:5]) + int'(tw[12:10]);
    bb = wl - (pre2 ? 3 : 2);
    apb(1'b0, OFS_STATUS, 32'h0);
    check(32'(rv[14:8]), 32'(wl));
    repeat (130) @(posedge pclk);
    chk_on = 1'b1;
  endtask

  // Random pin pulses, reads, writes and write-then-read pairs
  task automatic run(input int n);
    logic [31:0] r;
    repeat (n) begin
      r = $random(seed);
      if (r[0]) fork ctl.pin_pulse(int'(r[3:1])); join_none
      case (r[9:8])
        2'd1: ctl.cmd(1'b1, 1'b0, r[10]);
        2'd2: ctl.cmd(1'b0, 1'b1, r[10]);
        2'd3: begin
          ctl.cmd(1'b0, 1'b1, r[10]);
          repeat (3) @(posedge pclk);
          ctl.cmd(1'b1, 1'b0, r[11]);
        end
        default: ;
      endcase
      repeat (24 + int'(r[6:4])) @(posedge pclk);
    end
  endtask

  // Main sequence
  initial begin
    {pclk, presetn, psel, penable, pwrite, self_refresh} = 6'h0;
    {paddr, pwdata, cyc, n_fail, compares} = '0;
    {dll_locked, seed} = {1'b1, 32'd85604};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_TIMING, 32'h0);
    check(rv, TIM_RST);
    apb(1'b0, OFS_MODE, 32'h0);
    check(rv, MODE_RST);
    apb(1'b1, 8'h0c, 32'h5a5a_5a5a);
    check(32'(ev), 32'h1);
    apb(1'b0, 8'h0c, 32'h0);
    check({rv[31:1], ev}, 32'h1);
    apb(1'b1, OFS_TIMING, 32'hffff_ffff);
    apb(1'b0, OFS_TIMING, 32'h0);
    check(rv, TIM_MASK);
    for (int i = 0; i < 6; i++) begin
      cfg(tws[i], 32'hb3);
      run(12);
    end
    cfg(32'h9, 32'hb0);
    run(10);
    cfg(32'h9, 32'h03);
    run(10);
    // Unlocked DLL: pin must not raise nominal termination
    dll_locked <= 1'b0;
    run(6);
    dll_locked <= 1'b1;
    run(4);
    self_refresh <= 1'b1;
    run(6);
    self_refresh <= 1'b0;
    repeat (40) @(posedge pclk);
    end_sim();
  end
endmodule
